// File: verilog/rrx_pkg.sv
// Package: constants and types of the return and reset execution block
`default_nettype none
package rrx_pkg;
   // Widths and depths
   localparam int RRX_PC_W = 21;
   localparam int RRX_BANK_W = 4;
   localparam int RRX_DEPTH = 31;
   localparam int RRX_SP_W = 5;
   // Register map, 4-bit address, 8-bit data
   localparam logic [3:0] RRX_A_CTRL = 4'h0;
   localparam logic [3:0] RRX_A_W = 4'h1;
   localparam logic [3:0] RRX_A_STATUS = 4'h2;
   localparam logic [3:0] RRX_A_BANK = 4'h3;
   localparam logic [3:0] RRX_A_SHW = 4'h4;
   localparam logic [3:0] RRX_A_SHFLAGS = 4'h5;
   localparam logic [3:0] RRX_A_SHBANK = 4'h6;
   localparam logic [3:0] RRX_A_INTEN = 4'h7;
   localparam logic [3:0] RRX_A_PCL = 4'h8;
   localparam logic [3:0] RRX_A_PCH = 4'h9;
   localparam logic [3:0] RRX_A_PCU = 4'ha;
   localparam logic [3:0] RRX_A_PCHLAT = 4'hb;
   localparam logic [3:0] RRX_A_PCULAT = 4'hc;
   localparam logic [3:0] RRX_A_STACK = 4'hd;
   localparam logic [3:0] RRX_A_LAST = 4'he;
   // Field positions
   localparam int RRX_CTRL_HISEL = 0;
   localparam int RRX_INT_HIGH = 7;
   localparam int RRX_INT_LOW = 6;
   localparam int RRX_SP_FULL = 7;
   localparam int RRX_SP_UNDER = 6;
   // Reset values
   localparam logic [7:0] RRX_W_RST = 8'h00;
   localparam logic [7:0] RRX_STATUS_RST = 8'h00;
   localparam logic [RRX_BANK_W-1:0] RRX_BANK_RST = 4'h0;
   localparam logic [RRX_PC_W-1:0] RRX_PC_RST = 21'h00000;
   localparam logic [7:0] RRX_CTRL_RST = 8'h00;
   localparam logic [7:0] RRX_LATCH_RST = 8'h00;
   localparam logic RRX_INTEN_RST = 1'b0;
   // Opcodes
   localparam logic [15:0] RRX_OP_RESET = 16'h00ff;
   localparam logic [15:0] RRX_OP_RFI = 16'h0010;
   localparam logic [15:0] RRX_OP_RETURN = 16'h0012;
   localparam logic [15:0] RRX_OP_SMASK = 16'hfffe;
   localparam logic [7:0] RRX_OP_RLW = 8'h0c;
   // Last executed opcode class
   localparam logic [7:0] RRX_LAST_NONE = 8'h00;
   localparam logic [7:0] RRX_LAST_RFI = 8'h01;
   localparam logic [7:0] RRX_LAST_RLW = 8'h02;
   localparam logic [7:0] RRX_LAST_RSUB = 8'h03;
   localparam logic [7:0] RRX_LAST_UNK = 8'hff;
   // Quarter phases
   localparam logic [1:0] RRX_Q1 = 2'h0;
   localparam logic [1:0] RRX_Q2 = 2'h1;
   localparam logic [1:0] RRX_Q4 = 2'h3;
   // Types
   typedef enum logic [1:0] {RRX_IDLE, RRX_EXEC, RRX_SECOND} rrx_fsm_t;
   typedef struct packed {
      logic [7:0] w;
      logic [7:0] status;
      logic [RRX_BANK_W-1:0] bank;
   } rrx_ctx_t;
   typedef struct packed {
      logic stb;
      logic [RRX_PC_W-1:0] addr;
   } rrx_push_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rrx_bus_t;
endpackage : rrx_pkg
`default_nettype wire

// File: verilog/rrx_stack.sv
// Return address stack with pointer and overflow flags
`default_nettype none
module rrx_stack
   import rrx_pkg::*;
#(
   parameter int DEPTH = RRX_DEPTH,
   parameter int AW = RRX_PC_W,
   parameter int SPW = RRX_SP_W
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Push and pop
   input wire logic push,
   input wire logic [AW-1:0] push_addr,
   input wire logic pop,
   // Stack state
   output logic [AW-1:0] top,
   output logic [SPW-1:0] level,
   output logic full,
   output logic underflow
);
   typedef struct packed {
      logic [SPW-1:0] sp;
      logic full;
      logic under;
   } rrx_stk_t;

   rrx_stk_t st_q;
   rrx_stk_t st_d;
   logic [AW-1:0] mem_q [DEPTH];
   logic at_top;
   logic at_bot;

   assign at_top = st_q.sp == SPW'(DEPTH);
   assign at_bot = st_q.sp == '0;
   // Empty stack returns zero, like a cleared entry
   assign top = at_bot ? '0 : mem_q[st_q.sp - 1'b1];
   assign level = st_q.sp;
   assign full = st_q.full;
   assign underflow = st_q.under;

   always_comb
   begin
      st_d = st_q;
      if (push && pop && !at_bot)
         st_d.sp = st_q.sp;
      else if (pop)
      begin
         if (at_bot)
            st_d.under = 1'b1;
         else
            st_d.sp = st_q.sp - 1'b1;
      end
      else if (push)
      begin
         if (at_top)
            st_d.full = 1'b1;
         else
            st_d.sp = st_q.sp + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // Array kept out of reset; only the pointer matters
   always_ff @(posedge clk)
   begin
      if (push && pop && !at_bot)
         mem_q[st_q.sp - 1'b1] <= push_addr;
      else if (push && !pop && !at_top)
         mem_q[st_q.sp] <= push_addr;
   end
endmodule : rrx_stack
`default_nettype wire

// File: verilog/rrx_exec.sv
// Execution of the software reset and the three return instructions
`default_nettype none
// Function
// - Reset opcode restores all reset values at Q2
// - Interrupt return pops stack into PC
// - Interrupt return sets high or low enable
// - Interrupt return restores shadows when s set
// - Interrupt return alters status flags only when s set
// - Returns never touch the PC latches
// - Literal return writes W at Q4
// - Literal return pops stack into PC
// - Subroutine return pops stack, flags kept when s clear
// - Subroutine return restores shadows when s set
module rrx_exec
   import rrx_pkg::*;
#(
   parameter int DEPTH = RRX_DEPTH
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Instruction in, taken at Q1
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   // Pushes from call and interrupt logic
   input wire rrx_push_t PUSH,
   // Register port
   input wire rrx_bus_t REG_REQ,
   output logic [7:0] RDATA,
   // Core state
   output logic [RRX_PC_W-1:0] PC,
   output logic [7:0] W,
   output logic [7:0] STATUS,
   output logic [RRX_BANK_W-1:0] BANK,
   output logic INT_EN_HIGH,
   output logic INT_EN_LOW,
   output logic SOFT_RESET_OUT,
   output logic BUSY,
   output logic [1:0] QPHASE
);
   typedef struct packed {
      rrx_fsm_t fsm;
      logic [1:0] q;
      logic [15:0] ir;
      rrx_ctx_t live;
      rrx_ctx_t shadow;
      logic int_hi;
      logic int_lo;
      logic [RRX_PC_W-1:0] pc;
      logic [7:0] pc_hi_lat;
      logic [7:0] pc_up_lat;
      logic [7:0] ctrl;
      logic [7:0] last_op;
      logic [7:0] rdata;
      logic soft_rst;
      logic busy;
   } rrx_st_t;

   function automatic rrx_st_t rrx_rst_val();
      rrx_st_t r;
      r = '0;
      r.fsm = RRX_IDLE;
      r.q = RRX_Q1;
      r.live.w = RRX_W_RST;
      r.live.status = RRX_STATUS_RST;
      r.live.bank = RRX_BANK_RST;
      r.shadow.w = RRX_W_RST;
      r.shadow.status = RRX_STATUS_RST;
      r.shadow.bank = RRX_BANK_RST;
      r.int_hi = RRX_INTEN_RST;
      r.int_lo = RRX_INTEN_RST;
      r.pc = RRX_PC_RST;
      r.pc_hi_lat = RRX_LATCH_RST;
      r.pc_up_lat = RRX_LATCH_RST;
      r.ctrl = RRX_CTRL_RST;
      r.last_op = RRX_LAST_NONE;
      return r;
   endfunction : rrx_rst_val

   rrx_st_t st_q;
   rrx_st_t st_d;
   logic pop;
   logic is_rst;
   logic is_rfi;
   logic is_rsub;
   logic is_rlw;
   logic shad;
   logic at_q4;
   logic soft_go;
   logic ret_q4;
   logic stk_rst;
   logic [RRX_PC_W-1:0] stk_top;
   logic [RRX_SP_W-1:0] stk_level;
   logic stk_full;
   logic stk_under;

   // Decode of the held instruction word
   assign is_rst = st_q.ir == RRX_OP_RESET;
   assign is_rfi = (st_q.ir & RRX_OP_SMASK) == RRX_OP_RFI;
   assign is_rsub = (st_q.ir & RRX_OP_SMASK) == RRX_OP_RETURN;
   assign is_rlw = st_q.ir[15:8] == RRX_OP_RLW;
   assign shad = st_q.ir[0];
   assign at_q4 = st_q.fsm == RRX_EXEC && st_q.q == RRX_Q4;
   assign soft_go = st_q.fsm == RRX_EXEC && st_q.q == RRX_Q2 && is_rst;
   assign ret_q4 = at_q4 && (is_rfi || is_rsub || is_rlw);
   // Stack pointer is cleared by either reset source
   assign stk_rst = RESET || soft_go;

   rrx_stack #(
      .DEPTH(DEPTH),
      .AW(RRX_PC_W),
      .SPW(RRX_SP_W)
   ) u_stack (
      .clk(CLK),
      .reset(stk_rst),
      .push(PUSH.stb),
      .push_addr(PUSH.addr),
      .pop(pop),
      .top(stk_top),
      .level(stk_level),
      .full(stk_full),
      .underflow(stk_under)
   );

   always_comb
   begin
      st_d = st_q;
      pop = 1'b0;
      st_d.q = st_q.q + 2'h1;
      st_d.soft_rst = 1'b0;
      st_d.rdata = 8'h00;
      if (REG_REQ.rd)
      begin
         case (REG_REQ.addr)
            RRX_A_CTRL: st_d.rdata = st_q.ctrl;
            RRX_A_W: st_d.rdata = st_q.live.w;
            RRX_A_STATUS: st_d.rdata = st_q.live.status;
            RRX_A_BANK: st_d.rdata = 8'(st_q.live.bank);
            RRX_A_SHW: st_d.rdata = st_q.shadow.w;
            RRX_A_SHFLAGS: st_d.rdata = st_q.shadow.status;
            RRX_A_SHBANK: st_d.rdata = 8'(st_q.shadow.bank);
            RRX_A_INTEN:
            begin
               st_d.rdata[RRX_INT_HIGH] = st_q.int_hi;
               st_d.rdata[RRX_INT_LOW] = st_q.int_lo;
            end
            RRX_A_PCL: st_d.rdata = st_q.pc[7:0];
            RRX_A_PCH: st_d.rdata = st_q.pc[15:8];
            RRX_A_PCU: st_d.rdata = 8'(st_q.pc[RRX_PC_W-1:16]);
            RRX_A_PCHLAT: st_d.rdata = st_q.pc_hi_lat;
            RRX_A_PCULAT: st_d.rdata = st_q.pc_up_lat;
            RRX_A_STACK:
            begin
               st_d.rdata[RRX_SP_FULL] = stk_full;
               st_d.rdata[RRX_SP_UNDER] = stk_under;
               st_d.rdata[RRX_SP_W-1:0] = stk_level;
            end
            RRX_A_LAST: st_d.rdata = st_q.last_op;
            default: st_d.rdata = 8'h00;
         endcase
      end
      // Instruction effects below override a write in the same cycle
      if (REG_REQ.wr)
      begin
         case (REG_REQ.addr)
            RRX_A_CTRL: st_d.ctrl = REG_REQ.wdata;
            RRX_A_W: st_d.live.w = REG_REQ.wdata;
            RRX_A_STATUS: st_d.live.status = REG_REQ.wdata;
            RRX_A_BANK: st_d.live.bank = REG_REQ.wdata[RRX_BANK_W-1:0];
            RRX_A_SHW: st_d.shadow.w = REG_REQ.wdata;
            RRX_A_SHFLAGS: st_d.shadow.status = REG_REQ.wdata;
            RRX_A_SHBANK: st_d.shadow.bank = REG_REQ.wdata[RRX_BANK_W-1:0];
            RRX_A_INTEN:
            begin
               st_d.int_hi = REG_REQ.wdata[RRX_INT_HIGH];
               st_d.int_lo = REG_REQ.wdata[RRX_INT_LOW];
            end
            RRX_A_PCHLAT: st_d.pc_hi_lat = REG_REQ.wdata;
            RRX_A_PCULAT: st_d.pc_up_lat = REG_REQ.wdata;
            default: st_d.ctrl = st_q.ctrl;
         endcase
      end
      case (st_q.fsm)
         RRX_IDLE:
         begin
            if (st_q.q == RRX_Q1 && INSTR_VALID)
            begin
               st_d.ir = INSTR;
               st_d.fsm = RRX_EXEC;
            end
         end
         RRX_EXEC:
         begin
            if (soft_go)
            begin
               st_d = rrx_rst_val();
               st_d.soft_rst = 1'b1;
            end
            else if (at_q4)
            begin
               st_d.fsm = RRX_IDLE;
               st_d.last_op = RRX_LAST_UNK;
               if (ret_q4)
               begin
                  pop = 1'b1;
                  // Only PC reloads; both latches keep their value
                  st_d.pc = stk_top;
                  st_d.fsm = RRX_SECOND;
               end
               if (is_rfi)
               begin
                  st_d.last_op = RRX_LAST_RFI;
                  if (st_q.ctrl[RRX_CTRL_HISEL])
                     st_d.int_hi = 1'b1;
                  else
                     st_d.int_lo = 1'b1;
               end
               if (is_rsub)
                  st_d.last_op = RRX_LAST_RSUB;
               // Flags change only through the shadow restore
               if ((is_rfi || is_rsub) && shad)
                  st_d.live = st_q.shadow;
               if (is_rlw)
               begin
                  st_d.last_op = RRX_LAST_RLW;
                  st_d.live.w = st_q.ir[7:0];
               end
            end
         end
         RRX_SECOND:
         begin
            // Idle cycle while the new fetch is under way
            if (st_q.q == RRX_Q4)
               st_d.fsm = RRX_IDLE;
         end
         default: st_d.fsm = RRX_IDLE;
      endcase
      st_d.busy = st_d.fsm != RRX_IDLE;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         st_q <= rrx_rst_val();
      else
         st_q <= st_d;
   end

   assign RDATA = st_q.rdata;
   assign PC = st_q.pc;
   assign W = st_q.live.w;
   assign STATUS = st_q.live.status;
   assign BANK = st_q.live.bank;
   assign INT_EN_HIGH = st_q.int_hi;
   assign INT_EN_LOW = st_q.int_lo;
   assign SOFT_RESET_OUT = st_q.soft_rst;
   assign BUSY = st_q.busy;
   assign QPHASE = st_q.q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   property p_soft_reset;
      soft_go |=> SOFT_RESET_OUT && W == RRX_W_RST && PC == RRX_PC_RST
         && !INT_EN_HIGH && !INT_EN_LOW && !BUSY && stk_level == '0 && QPHASE == RRX_Q1;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("software reset did not restore reset state");

   property p_rfi_pc;
      (ret_q4 && is_rfi) |=> PC == $past(stk_top);
   endproperty
   a_rfi_pc: assert property (p_rfi_pc)
      else $error("interrupt return did not load PC from stack");

   property p_rfi_gie;
      (ret_q4 && is_rfi && !REG_REQ.wr)
         |=> ($past(st_q.ctrl[RRX_CTRL_HISEL]) ? INT_EN_HIGH : INT_EN_LOW);
   endproperty
   a_rfi_gie: assert property (p_rfi_gie)
      else $error("interrupt return did not set enable");

   property p_rfi_shadow;
      (ret_q4 && is_rfi && !REG_REQ.wr)
         |=> W == $past(shad ? st_q.shadow.w : st_q.live.w)
         && BANK == $past(shad ? st_q.shadow.bank : st_q.live.bank);
   endproperty
   a_rfi_shadow: assert property (p_rfi_shadow)
      else $error("interrupt return shadow restore wrong");

   property p_rfi_flags;
      (ret_q4 && is_rfi && !REG_REQ.wr)
         |=> STATUS == $past(shad ? st_q.shadow.status : st_q.live.status);
   endproperty
   a_rfi_flags: assert property (p_rfi_flags)
      else $error("interrupt return changed status flags");

   sequence s_take_two;
      st_q.fsm == RRX_IDLE && st_q.q == RRX_Q1 && INSTR_VALID
         && (INSTR[15:8] == RRX_OP_RLW || (INSTR & RRX_OP_SMASK) == RRX_OP_RFI);
   endsequence
   sequence s_busy_two;
      BUSY [*7] ##1 !BUSY;
   endsequence
   property p_two_cycle;
      s_take_two |=> s_busy_two;
   endproperty
   a_two_cycle: assert property (p_two_cycle)
      else $error("two-cycle return timing wrong");

   property p_second_idle;
      (st_q.fsm == RRX_SECOND && !REG_REQ.wr) |=> $stable(PC) && $stable(W) && $stable(STATUS);
   endproperty
   a_second_idle: assert property (p_second_idle)
      else $error("second return cycle changed state");

   property p_latches;
      (ret_q4 && !REG_REQ.wr) |=> $stable(st_q.pc_hi_lat) && $stable(st_q.pc_up_lat);
   endproperty
   a_latches: assert property (p_latches)
      else $error("return changed a PC latch");

   property p_rlw_w;
      (ret_q4 && is_rlw && !REG_REQ.wr) |=> W == $past(st_q.ir[7:0]) && $stable(STATUS);
   endproperty
   a_rlw_w: assert property (p_rlw_w)
      else $error("literal return W or flags wrong");

   property p_rlw_pc;
      (ret_q4 && is_rlw) |=> PC == $past(stk_top);
   endproperty
   a_rlw_pc: assert property (p_rlw_pc)
      else $error("literal return did not load PC from stack");

   property p_rsub;
      (ret_q4 && is_rsub && !REG_REQ.wr)
         |=> (PC == $past(stk_top) && STATUS == $past(shad ? st_q.shadow.status : STATUS))
         ##0 BUSY [*4] ##1 !BUSY;
   endproperty
   a_rsub: assert property (p_rsub)
      else $error("subroutine return PC, flags or timing wrong");

   property p_rsub_shadow;
      (ret_q4 && is_rsub && shad && !REG_REQ.wr)
         |=> W == $past(st_q.shadow.w) && BANK == $past(st_q.shadow.bank);
   endproperty
   a_rsub_shadow: assert property (p_rsub_shadow)
      else $error("subroutine return shadow restore wrong");

   property p_pop_level;
      (pop && !PUSH.stb && stk_level != '0) |=> stk_level == $past(stk_level) - 1'b1;
   endproperty
   a_pop_level: assert property (p_pop_level)
      else $error("pop did not lower stack level by one");
endmodule : rrx_exec
`default_nettype wire

// File: test/return_reset_instr_exec_bench.sv
// Self-checking bench for the return and reset execution block
`default_nettype none
module return_reset_instr_exec_bench
   import rrx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic reset;
   logic instr_valid;
   logic [15:0] instr;
   rrx_push_t push_s;
   rrx_bus_t req;
   logic [7:0] rdata;
   logic [RRX_PC_W-1:0] pc;
   logic [7:0] w;
   logic [7:0] status;
   logic [RRX_BANK_W-1:0] bank;
   logic int_hi;
   logic int_lo;
   logic soft_out;
   logic busy;
   logic [1:0] qphase;
   int miscompares;
   int n_compared;
   int n_cycles;
   int n_soft;
   int nb;
   logic [7:0] lh_exp;
   logic [7:0] lu_exp;

   rrx_exec #(.DEPTH(RRX_DEPTH)) DUT (
      .CLK(clk),
      .RESET(reset),
      .INSTR_VALID(instr_valid),
      .INSTR(instr),
      .PUSH(push_s),
      .REG_REQ(req),
      .RDATA(rdata),
      .PC(pc),
      .W(w),
      .STATUS(status),
      .BANK(bank),
      .INT_EN_HIGH(int_hi),
      .INT_EN_LOW(int_lo),
      .SOFT_RESET_OUT(soft_out),
      .BUSY(busy),
      .QPHASE(qphase)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Sampled mid-cycle so the pulse is never lost to edge ordering
   always @(negedge clk)
   begin
      if (soft_out === 1'b1)
      begin
         n_soft++;
      end
   end

   // Run needs under two hundred cycles; generous ceiling
   always @(posedge clk)
   begin
      n_cycles++;
      if (n_cycles == 3000)
      begin
         miscompares++;
         $display("MISMATCH at %0t: run timed out", $time);
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp, what);
   endtask : rdc

   task automatic push(input logic [RRX_PC_W-1:0] a);
      @(posedge clk);
      push_s <= '{stb: 1'b1, addr: a};
      @(posedge clk);
      push_s.stb <= 1'b0;
   endtask : push

   // Valid held through the first busy cycle; n counts busy cycles
   task automatic exec(input logic [15:0] op, output int n);
      int k;
      k = 0;
      n = 1;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= op;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (busy !== 1'b1 && k < 20);
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      while (busy === 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk);
         #1;
      end
   endtask : exec

   task automatic core(input logic [RRX_PC_W-1:0] p, input logic [7:0] wv,
      input logic [7:0] sv, input logic [3:0] bv, input logic [7:0] lvl,
      input logic [7:0] last);
      chk(pc, p, "pc");
      chk(w, wv, "w");
      chk(status, sv, "status");
      chk(bank, bv, "bank");
      rdc(RRX_A_STACK, lvl, "stack");
      rdc(RRX_A_LAST, last, "last op");
      rdc(RRX_A_PCHLAT, lh_exp, "high latch");
      rdc(RRX_A_PCULAT, lu_exp, "upper latch");
   endtask : core

   initial
   begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      push_s = '0;
      req = '0;
      miscompares = 0;
      n_compared = 0;
      n_cycles = 0;
      n_soft = 0;
      lh_exp = 8'h00;
      lu_exp = 8'h00;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      #1;
      core(21'h00000, 8'h00, 8'h00, 4'h0, 8'h00, RRX_LAST_NONE);
      chk({int_hi, int_lo}, 2'b00, "enables");
      chk(qphase, RRX_Q1, "phase after reset");
      rdc(4'hf, 8'h00, "unmapped");
      // Live context, shadows and latches all distinct
      wr(RRX_A_W, 8'h11);
      wr(RRX_A_STATUS, 8'h22);
      wr(RRX_A_BANK, 8'h03);
      wr(RRX_A_SHW, 8'ha5);
      wr(RRX_A_SHFLAGS, 8'h5a);
      wr(RRX_A_SHBANK, 8'h0c);
      wr(RRX_A_PCHLAT, 8'h12);
      wr(RRX_A_PCULAT, 8'h34);
      lh_exp = 8'h12;
      lu_exp = 8'h34;
      push(21'h1abcd);
      push(21'h00246);
      push(21'h13579);
      push(21'h0aaaa);
      // Literal return
      exec(16'h0c55, nb);
      chk(nb, 7, "literal return busy");
      core(21'h0aaaa, 8'h55, 8'h22, 4'h3, 8'h03, RRX_LAST_RLW);
      // Subroutine return, shadows off then on
      exec(RRX_OP_RETURN, nb);
      chk(nb, 7, "sub return busy");
      core(21'h13579, 8'h55, 8'h22, 4'h3, 8'h02, RRX_LAST_RSUB);
      exec(RRX_OP_RETURN | 16'h0001, nb);
      core(21'h00246, 8'ha5, 8'h5a, 4'hc, 8'h01, RRX_LAST_RSUB);
      // Interrupt return to the high enable, context kept
      wr(RRX_A_CTRL, 8'h01);
      wr(RRX_A_W, 8'h01);
      wr(RRX_A_STATUS, 8'h02);
      wr(RRX_A_BANK, 8'h01);
      exec(RRX_OP_RFI, nb);
      chk(nb, 7, "int return busy");
      core(21'h1abcd, 8'h01, 8'h02, 4'h1, 8'h00, RRX_LAST_RFI);
      chk({int_hi, int_lo}, 2'b10, "high enable");
      rdc(RRX_A_INTEN, 8'h80, "enable reg");
      // Low enable with shadows restored
      wr(RRX_A_CTRL, 8'h00);
      push(21'h00100);
      exec(RRX_OP_RFI | 16'h0001, nb);
      core(21'h00100, 8'ha5, 8'h5a, 4'hc, 8'h00, RRX_LAST_RFI);
      chk({int_hi, int_lo}, 2'b11, "low enable");
      // Unrelated opcode leaves the context alone
      exec(16'h0000, nb);
      chk(nb, 3, "other op busy");
      core(21'h00100, 8'ha5, 8'h5a, 4'hc, 8'h00, RRX_LAST_UNK);
      // Software reset with non-zero state everywhere
      wr(RRX_A_CTRL, 8'h01);
      push(21'h00777);
      exec(RRX_OP_RESET, nb);
      chk(nb, 1, "reset op busy");
      lh_exp = 8'h00;
      lu_exp = 8'h00;
      core(21'h00000, 8'h00, 8'h00, 4'h0, 8'h00, RRX_LAST_NONE);
      chk({int_hi, int_lo}, 2'b00, "enables cleared");
      rdc(RRX_A_CTRL, 8'h00, "ctrl cleared");
      rdc(RRX_A_SHW, 8'h00, "shadow cleared");
      chk(n_soft, 1, "soft reset pulses");
      print_verdict();
   end
endmodule : return_reset_instr_exec_bench
`default_nettype wire
